// file: pkg/mt_tracker_consts.svh
// offsets, field positions, reset values and timing counts
`ifndef MT_TRACKER_CONSTS_SVH
`define MT_TRACKER_CONSTS_SVH
`define OFS_MODE        4'h0
`define OFS_ROT_LIMIT   4'h4
`define OFS_STATUS      4'h8
`define OFS_TURNS       4'hC
`define MODE_INCR       16'h0000
`define MODE_LINEAR     16'h0001
`define MODE_ROTARY     16'h0002
`define MODE_SINGLE     16'h0003
`define MODE_CLR_ALARM  16'h0005
`define MODE_CLR_TURNS  16'h0009
`define MODE_RST        16'h0000
`define ROT_LIMIT_RST   16'h7FFF
`define TURNS_MAX       16'sh7FFF
`define TURNS_MIN       16'sh8000
`define ST_MASK_17      23'h01FFFF
`define ST_MASK_23      23'h7FFFFF
`define STAT_ALARM_BIT  0
`define STAT_VALID_BIT  1
`define STAT_LOW_BIT    2
`define STAT_DEAD_BIT   3
`define STAT_RANGE_BIT  4
`define CLR_TIME_MS     3000
`define CLK_HZ          20000000
`define CLR_CYCLES      ((`CLK_HZ / 1000) * `CLR_TIME_MS)
`endif

// file: pkg/mt_tracker_pkg.sv
// types shared by the multiturn position tracker
package mt_tracker_pkg;
    typedef struct packed {
        logic        step_valid;
        logic        step_ccw;
        logic [22:0] single_pos;
        logic        res_23bit;
    } enc_sample_t;

    typedef struct packed {
        logic battery_low;
        logic battery_dead;
        logic first_use;
    } battery_t;

    typedef enum logic [1:0] {
        CLR_IDLE,
        CLR_BUSY,
        CLR_FAIL
    } clr_state_t;
endpackage

// file: logic/turn_counter.sv
// revolution counter with linear and rotary wrap
`timescale 1ns/1ps
`include "mt_tracker_consts.svh"
module turn_counter
    import mt_tracker_pkg::*;
(
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    input  wire logic        step_in,
    input  wire logic        ccw_in,
    input  wire logic        rotary_in,
    input  wire logic [15:0] limit_in,
    input  wire logic        zero_in,
    input  wire logic        keep_in,
    input  wire logic        multiturn_in,
    input  wire logic signed [15:0] keep_value_in,
    output logic signed [15:0] turns_out
);
    logic signed [15:0] turns_r;
    logic signed [15:0] turns_nxt;
    logic               restore_r;
    logic signed [15:0] keep_r;
    logic               load;

    assign load = restore_r && multiturn_in;

    always_comb begin
        turns_nxt = turns_r;
        if (zero_in) begin
            turns_nxt = 16'sh0000;
        end else if (load) begin
            turns_nxt = keep_r;
        end else if (step_in && rotary_in) begin
            // rotary keeps 0..limit in both directions
            if (ccw_in) begin
                turns_nxt = (turns_r >= $signed(limit_in)) ?
                    16'sh0000 : 16'(turns_r + 16'sh0001);
            end else begin
                turns_nxt = (turns_r <= 16'sh0000) ?
                    $signed(limit_in) : 16'(turns_r - 16'sh0001);
            end
        end else if (step_in) begin
            // natural two's complement wrap gives +32767 -> -32768
            turns_nxt = ccw_in ? 16'(turns_r + 16'sh0001)
                               : 16'(turns_r - 16'sh0001);
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            turns_r <= 16'sh0000;
        end else begin
            turns_r <= turns_nxt;
        end
    end

    // retained count waits until software picks a multiturn mode
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            restore_r <= 1'b0;
            keep_r    <= 16'sh0000;
        end else if (keep_in) begin
            restore_r <= 1'b1;
            keep_r    <= keep_value_in;
        end else if (load || zero_in) begin
            restore_r <= 1'b0;
        end
    end

    assign turns_out = turns_r;

    a_wrap_ccw: assert property (@(posedge clk_in) disable iff (rst_in)
        (step_in && ccw_in && !rotary_in && !zero_in && !load
         && turns_r == `TURNS_MAX) |=> turns_r == `TURNS_MIN)
        else $error("ccw wrap missed");
    a_rotary_range: assert property (@(posedge clk_in) disable iff (rst_in)
        (step_in && rotary_in && !zero_in && !load && turns_r >= 16'sh0000
         && turns_r <= $signed(limit_in) && $stable(limit_in))
        |=> turns_r >= 16'sh0000)
        else $error("rotary count negative");
endmodule // turn_counter

// file: logic/mt_position_tracker.sv
// multiturn absolute position tracker with avalon register slave
//
// Design decisions made here: the Avalon-MM register port and the register offsets.
`timescale 1ns/1ps
`include "mt_tracker_consts.svh"
module mt_position_tracker
    import mt_tracker_pkg::*;
#(
    parameter int unsigned CLR_TIMEOUT = `CLR_CYCLES
) (
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    input  wire logic [3:0]  avs_address_in,
    input  wire logic        avs_read_in,
    input  wire logic        avs_write_in,
    input  wire logic [31:0] avs_writedata_in,
    input  wire logic [3:0]  avs_byteenable_in,
    output logic [31:0]      avs_readdata_out,
    output logic             avs_waitrequest_out,
    input  wire enc_sample_t enc_in,
    input  wire battery_t    battery_in,
    input  wire logic [22:0] home_offset_in,
    input  wire logic [22:0] target_pos_in,
    input  wire logic        retained_valid_in,
    input  wire logic signed [15:0] retained_turns_in,
    output logic             alarm_output_pin_out,
    output logic             halt_out,
    output logic             target_ok_out,
    output logic signed [15:0] turns_out,
    output logic [22:0]      single_pos_out,
    output logic             pos_valid_out
);
    logic [15:0]        encoder_mode_setting_r;
    logic [15:0]        rotary_turn_upper_limit_r;
    logic               alarm_r;
    logic               latched_r;
    logic               range_err_r;
    logic               powerup_r;
    logic               answered_r;
    clr_state_t         clr_state_r;
    logic [31:0]        clr_cnt_r;
    logic signed [15:0] turns_w;
    logic               zero_turns;
    logic               do_clear;
    logic               step_ok;
    logic               access;
    logic               wr_take;
    logic [22:0]        res_mask;
    logic [23:0]        tgt_rel;

    assign access     = (avs_read_in || avs_write_in) && !answered_r;
    // writes land on the answer edge, when waitrequest is seen low
    assign wr_take    = avs_write_in && !avs_waitrequest_out;
    assign res_mask   = enc_in.res_23bit ? `ST_MASK_23 : `ST_MASK_17;
    // clears only take effect once the battery is healthy again
    assign do_clear   = clr_state_r == CLR_BUSY && !battery_in.battery_low
                        && !battery_in.battery_dead;
    assign zero_turns = (do_clear
                        && encoder_mode_setting_r == `MODE_CLR_TURNS)
                        || (powerup_r && !retained_valid_in);
    // counting stops while alarmed; single-turn mode never counts turns
    assign step_ok    = enc_in.step_valid && !alarm_r
                        && encoder_mode_setting_r != `MODE_SINGLE;

    turn_counter u_turns (
        .clk_in    (clk_in),
        .rst_in    (rst_in),
        .step_in   (step_ok),
        .ccw_in    (enc_in.step_ccw),
        .rotary_in (encoder_mode_setting_r == `MODE_ROTARY),
        .limit_in  (rotary_turn_upper_limit_r),
        .zero_in   (zero_turns),
        .keep_in   (powerup_r && retained_valid_in),
        .multiturn_in  (!alarm_r && (encoder_mode_setting_r == `MODE_LINEAR
                        || encoder_mode_setting_r == `MODE_ROTARY)),
        .keep_value_in (retained_turns_in),
        .turns_out (turns_w)
    );

    // avalon slave: one wait cycle, answer on the second edge
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            answered_r <= 1'b0;
        end else begin
            answered_r <= access;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            avs_waitrequest_out <= 1'b1;
        end else begin
            avs_waitrequest_out <= !access;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            avs_readdata_out <= 32'h0000_0000;
        end else if (access && avs_read_in) begin
            case (avs_address_in)
                `OFS_MODE:
                    avs_readdata_out <= {16'h0000, encoder_mode_setting_r};
                `OFS_ROT_LIMIT:
                    avs_readdata_out <= {16'h0000, rotary_turn_upper_limit_r};
                `OFS_STATUS:
                    avs_readdata_out <= {27'h0000000, range_err_r,
                        battery_in.battery_dead, battery_in.battery_low,
                        !alarm_r, alarm_r};
                `OFS_TURNS:
                    avs_readdata_out <= {{16{turns_w[15]}}, turns_w};
                default:
                    avs_readdata_out <= 32'h0000_0000;
            endcase
        end
    end

    // mode register; 5 and 9 revert to linear multiturn when done
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            encoder_mode_setting_r <= `MODE_RST;
        end else if (wr_take && avs_address_in == `OFS_MODE) begin
            if (avs_byteenable_in[0]) begin
                encoder_mode_setting_r[7:0] <= avs_writedata_in[7:0];
            end
            if (avs_byteenable_in[1]) begin
                encoder_mode_setting_r[15:8] <= avs_writedata_in[15:8];
            end
        end else if (do_clear) begin
            encoder_mode_setting_r <= `MODE_LINEAR;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            rotary_turn_upper_limit_r <= `ROT_LIMIT_RST;
        end else if (wr_take && avs_address_in == `OFS_ROT_LIMIT) begin
            if (avs_byteenable_in[0]) begin
                rotary_turn_upper_limit_r[7:0] <= avs_writedata_in[7:0];
            end
            if (avs_byteenable_in[1]) begin
                rotary_turn_upper_limit_r[15:8] <= avs_writedata_in[15:8];
            end
        end
    end

    // clear sequencer with 3 s failure window
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            clr_state_r <= CLR_IDLE;
            clr_cnt_r   <= 32'h0000_0000;
        end else begin
            case (clr_state_r)
                CLR_IDLE: begin
                    clr_cnt_r <= 32'h0000_0000;
                    if (encoder_mode_setting_r == `MODE_CLR_ALARM
                        || encoder_mode_setting_r == `MODE_CLR_TURNS) begin
                        clr_state_r <= CLR_BUSY;
                    end
                end
                CLR_BUSY: begin
                    clr_cnt_r <= clr_cnt_r + 32'h0000_0001;
                    if (do_clear) begin
                        clr_state_r <= CLR_IDLE;
                    end else if (clr_cnt_r >= CLR_TIMEOUT - 1) begin
                        clr_state_r <= CLR_FAIL;
                    end
                end
                CLR_FAIL: begin
                    if (encoder_mode_setting_r != `MODE_CLR_ALARM
                        && encoder_mode_setting_r != `MODE_CLR_TURNS) begin
                        clr_state_r <= CLR_IDLE;
                    end
                end
                default: clr_state_r <= CLR_IDLE;
            endcase
        end
    end

    // power-up: one cycle after reset adopts retained data
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            powerup_r <= 1'b1;
        end else begin
            powerup_r <= 1'b0;
        end
    end

    // deep faults need a turn clear; low battery alone clears on restart
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            latched_r <= 1'b0;
        end else if (battery_in.battery_dead
                     || battery_in.first_use) begin
            latched_r <= 1'b1;
        end else if (do_clear
                     && encoder_mode_setting_r == `MODE_CLR_TURNS) begin
            latched_r <= 1'b0;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            range_err_r <= 1'b0;
        end else if (encoder_mode_setting_r == `MODE_SINGLE
                     && enc_in.step_valid) begin
            range_err_r <= 1'b1;
        end else if (do_clear) begin
            range_err_r <= 1'b0;
        end
    end

    // set wins over clear; incremental mode holds the alarm clear whatever the battery state
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            alarm_r <= 1'b0;
        // a range error is a source that the clear itself removes
        end else if (encoder_mode_setting_r != `MODE_INCR
                     && ((range_err_r && !do_clear)
                     || battery_in.battery_low
                     || battery_in.battery_dead || battery_in.first_use
                     || (latched_r && !(do_clear
                     && encoder_mode_setting_r == `MODE_CLR_TURNS)))) begin
            alarm_r <= 1'b1;
        end else if (encoder_mode_setting_r == `MODE_INCR || do_clear) begin
            alarm_r <= 1'b0;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            alarm_output_pin_out <= 1'b0;
            halt_out             <= 1'b0;
            pos_valid_out        <= 1'b0;
        end else begin
            alarm_output_pin_out <= alarm_r;
            halt_out             <= alarm_r;
            pos_valid_out        <= !alarm_r && !latched_r;
        end
    end

    assign tgt_rel = {1'b0, target_pos_in} - {1'b0, home_offset_in};

    // a borrow means the target lies below the home offset
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            target_ok_out <= 1'b0;
        end else begin
            target_ok_out <= encoder_mode_setting_r != `MODE_SINGLE
                             || (enc_in.res_23bit
                             && !tgt_rel[23]);
        end
    end

    // retained turns are adopted inside the counter, not here
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            turns_out <= 16'sh0000;
        end else begin
            turns_out <= turns_w;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            single_pos_out <= 23'h000000;
        end else begin
            single_pos_out <= enc_in.single_pos & res_mask;
        end
    end

    a_halt_follows: assert property (@(posedge clk_in) disable iff (rst_in)
        alarm_r |=> ##0 (alarm_output_pin_out && halt_out))
        else $error("alarm not on pin");
    a_low_bat: assert property (@(posedge clk_in) disable iff (rst_in)
        (battery_in.battery_low && encoder_mode_setting_r != `MODE_INCR)
        |=> alarm_r)
        else $error("low battery not alarmed");
    a_dead_hold: assert property (@(posedge clk_in) disable iff (rst_in)
        (latched_r && encoder_mode_setting_r == `MODE_LINEAR) |=> alarm_r)
        else $error("dead battery alarm dropped");
    a_first_use: assert property (@(posedge clk_in) disable iff (rst_in)
        battery_in.first_use |=> latched_r ##1 !pos_valid_out)
        else $error("first use not flagged");
    a_clr_revert: assert property (@(posedge clk_in) disable iff (rst_in)
        do_clear |=> encoder_mode_setting_r == `MODE_LINEAR
        || $past(avs_write_in))
        else $error("clear did not revert mode");
    a_zero_turns: assert property (@(posedge clk_in) disable iff (rst_in)
        (do_clear && encoder_mode_setting_r == `MODE_CLR_TURNS)
        |=> turns_w == 16'sh0000)
        else $error("turn clear failed");
    a_single_alarm: assert property (@(posedge clk_in) disable iff (rst_in)
        (encoder_mode_setting_r == `MODE_SINGLE && enc_in.step_valid)
        |=> ##1 alarm_r)
        else $error("single-turn overflow not alarmed");
    a_no_count_alarm: assert property (@(posedge clk_in) disable iff (rst_in)
        (alarm_r && !zero_turns) |=> $stable(turns_w))
        else $error("count moved under alarm");
    a_pos_mask: assert property (@(posedge clk_in) disable iff (rst_in)
        !enc_in.res_23bit |=> single_pos_out[22:17] == 6'h00)
        else $error("17-bit position out of range");
endmodule // mt_position_tracker

// file: dv/enc_model.sv
// behavioural battery-backed multiturn encoder for the tracker bench
`timescale 1ns/1ps
module enc_model
    import mt_tracker_pkg::*;
(
    input  wire logic  clk_in,
    output enc_sample_t enc_out,
    output battery_t    battery_out
);
    initial begin
        enc_out     = '0;
        battery_out = '0;
    end

    // one pulse per revolution, a quiet cycle between pulses
    task automatic turn(input int n, input logic ccw);
        repeat (n) begin
            @(posedge clk_in);
            enc_out.step_valid <= 1'b1;
            enc_out.step_ccw   <= ccw;
            @(posedge clk_in);
            enc_out.step_valid <= 1'b0;
        end
    endtask

    // raw single-turn angle, not masked here on purpose
    task automatic set_pos(input logic [22:0] p, input logic r23);
        @(posedge clk_in);
        enc_out.single_pos <= p;
        enc_out.res_23bit  <= r23;
    endtask

    task automatic set_batt(input battery_t b);
        @(posedge clk_in);
        battery_out <= b;
    endtask
endmodule // enc_model

// file: dv/tb.sv
// self-checking bench for the multiturn position tracker
`timescale 1ns/1ps
`include "mt_tracker_consts.svh"
module tb
    import mt_tracker_pkg::*;
;
    localparam int unsigned CLR_T = 20;
    typedef struct {
        logic [3:0]  a;
        logic [31:0] m;
        logic [31:0] v;
    } note_t;

    logic               clk;
    logic               rst;
    logic [3:0]         addr;
    logic               rd_en;
    logic               wr_en;
    logic [31:0]        wdata;
    logic [31:0]        rdata;
    logic               wreq;
    enc_sample_t        enc;
    battery_t           batt;
    logic [22:0]        home_ofs;
    logic [22:0]        tgt;
    logic               alarm;
    logic               halt;
    logic               tgt_ok;
    logic               pvalid;
    logic signed [15:0] turns;
    logic [22:0]        spos;
    logic [3:0]         be;
    logic               ret_valid;
    logic signed [15:0] ret_turns;
    int                 num_errors = 0;
    int                 checked = 0;
    int                 cycles = 0;
    note_t              notes[$];
    note_t              cur;

    initial clk = 1'b0;
    always #25 clk = ~clk;

    enc_model enc_model_i (
        .clk_in      (clk),
        .enc_out     (enc),
        .battery_out (batt)
    );

    // retained turns are offered on one restart only
    mt_position_tracker #(.CLR_TIMEOUT(CLR_T)) mt_position_tracker_i (
        .clk_in               (clk),
        .rst_in               (rst),
        .avs_address_in       (addr),
        .avs_read_in          (rd_en),
        .avs_write_in         (wr_en),
        .avs_writedata_in     (wdata),
        .avs_byteenable_in    (be),
        .avs_readdata_out     (rdata),
        .avs_waitrequest_out  (wreq),
        .enc_in               (enc),
        .battery_in           (batt),
        .home_offset_in       (home_ofs),
        .target_pos_in        (tgt),
        .retained_valid_in    (ret_valid),
        .retained_turns_in    (ret_turns),
        .alarm_output_pin_out (alarm),
        .halt_out             (halt),
        .target_ok_out        (tgt_ok),
        .turns_out            (turns),
        .single_pos_out       (spos),
        .pos_valid_out        (pvalid)
    );

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic cmp(input string nm, input logic [31:0] exp,
                       input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // read notes are taken off the queue at the answer edge
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 80000) begin
            num_errors++;
            give_verdict();
        end
        if (rd_en && wreq === 1'b0 && notes.size() > 0) begin
            cur = notes.pop_front();
            if (cur.m != 32'h0)
                cmp($sformatf("reg %h", cur.a), cur.v, rdata & cur.m);
        end
    end

    task automatic bus(input logic wr, input logic [3:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr_en <= wr;
        rd_en <= ~wr;
        do begin
            @(posedge clk);
            n++;
        end while (wreq !== 1'b0 && n < 100);
        q = rdata;
        if (n >= 100)
            num_errors++;
        rd_en <= 1'b0;
        wr_en <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, input logic [31:0] m,
                      input logic [31:0] v);
        logic [31:0] q;
        notes.push_back('{a, m, v});
        bus(1'b0, a, 32'h0, q);
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        logic [31:0] q;
        bus(1'b1, a, {16'h0, d}, q);
    endtask

    // a clear may take many cycles, so poll with a bound
    task automatic wait_mode(input logic [15:0] v);
        logic [31:0] q;
        int n;
        n = 0;
        q = '1;
        while (q[15:0] !== v && n < 40) begin
            notes.push_back('{`OFS_MODE, 32'h0, 32'h0});
            bus(1'b0, `OFS_MODE, 32'h0, q);
            n++;
        end
        rd(`OFS_MODE, 32'hFFFF, {16'h0, v});
    endtask

    task automatic settle();
        repeat (3) @(posedge clk);
    endtask

    task automatic restart();
        @(posedge clk);
        rst <= 1'b1;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
    endtask

    initial begin
        logic [22:0] p;
        battery_t    b;
        logic [31:0] r;
        rst      = 1'b1;
        addr     = 4'h0;
        rd_en    = 1'b0;
        wr_en    = 1'b0;
        wdata    = 32'h0;
        home_ofs = 23'h0;
        tgt      = 23'h0;
        be       = 4'h3;
        ret_valid = 1'b0;
        ret_turns = 16'sh0000;
        p = 23'($urandom(32'hF39474C9));
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        rd(`OFS_MODE, 32'hFFFF, 32'h0);
        rd(`OFS_ROT_LIMIT, 32'hFFFF, {16'h0, `ROT_LIMIT_RST});
        rd(4'h2, 32'hFFFFFFFF, 32'h0);
        be <= 4'h1;
        wr(`OFS_ROT_LIMIT, 16'h1234);
        rd(`OFS_ROT_LIMIT, 32'hFFFF, 32'h7F34);
        be <= 4'h3;
        cmp("alarm", 32'h0, {31'h0, alarm});
        $display("test reset done");
        enc_model_i.set_pos(p, 1'b1);
        wr(`OFS_MODE, `MODE_CLR_TURNS);
        wait_mode(`MODE_LINEAR);
        rd(`OFS_TURNS, 32'hFFFFFFFF, 32'h0);
        enc_model_i.turn(3, 1'b1);
        rd(`OFS_TURNS, 32'hFFFFFFFF, 32'h3);
        enc_model_i.turn(5, 1'b0);
        rd(`OFS_TURNS, 32'hFFFFFFFF, 32'hFFFFFFFE);
        rd(`OFS_TURNS, 32'hFFFFFFFF, 32'hFFFFFFFE);
        cmp("turns", 32'hFFFE, {16'h0, turns});
        wr(`OFS_MODE, `MODE_CLR_TURNS);
        wait_mode(`MODE_LINEAR);
        rd(`OFS_TURNS, 32'hFFFFFFFF, 32'h0);
        cmp("single", {9'h0, p}, {9'h0, spos});
        enc_model_i.set_pos(23'h7FFFFF, 1'b0);
        settle();
        cmp("single", {9'h0, `ST_MASK_17}, {9'h0, spos});
        enc_model_i.set_pos(23'h7FFFFF, 1'b1);
        settle();
        cmp("single", {9'h0, `ST_MASK_23}, {9'h0, spos});
        $display("test count done");
        enc_model_i.turn(32767, 1'b1);
        rd(`OFS_TURNS, 32'hFFFFFFFF, 32'h00007FFF);
        enc_model_i.turn(1, 1'b1);
        rd(`OFS_TURNS, 32'hFFFFFFFF, 32'hFFFF8000);
        enc_model_i.turn(1, 1'b0);
        rd(`OFS_TURNS, 32'hFFFFFFFF, 32'h00007FFF);
        $display("test wrap done");
        wr(`OFS_MODE, `MODE_CLR_TURNS);
        wait_mode(`MODE_LINEAR);
        wr(`OFS_ROT_LIMIT, 16'h0003);
        wr(`OFS_MODE, `MODE_ROTARY);
        rd(`OFS_MODE, 32'hFFFF, {16'h0, `MODE_ROTARY});
        enc_model_i.turn(4, 1'b1);
        rd(`OFS_TURNS, 32'hFFFFFFFF, 32'h0);
        enc_model_i.turn(1, 1'b0);
        rd(`OFS_TURNS, 32'hFFFFFFFF, 32'h3);
        $display("test rotary done");
        wr(`OFS_MODE, `MODE_SINGLE);
        p = 23'($urandom()) | 23'h1;
        home_ofs <= p;
        tgt      <= p;
        settle();
        cmp("target ok", 32'h1, {31'h0, tgt_ok});
        tgt <= p - 23'h1;
        settle();
        cmp("target ok", 32'h0, {31'h0, tgt_ok});
        enc_model_i.turn(1, 1'b1);
        rd(`OFS_STATUS, 32'h11, 32'h11);
        cmp("alarm", 32'h1, {31'h0, alarm});
        cmp("halt", 32'h1, {31'h0, halt});
        wr(`OFS_MODE, `MODE_CLR_ALARM);
        wait_mode(`MODE_LINEAR);
        settle();
        cmp("alarm", 32'h0, {31'h0, alarm});
        cmp("halt", 32'h0, {31'h0, halt});
        $display("test single done");
        b = '0;
        b.battery_low = 1'b1;
        enc_model_i.set_batt(b);
        settle();
        cmp("alarm", 32'h1, {31'h0, alarm});
        rd(`OFS_STATUS, 32'h5, 32'h5);
        wr(`OFS_MODE, `MODE_CLR_ALARM);
        repeat (CLR_T + 10) @(posedge clk);
        rd(`OFS_MODE, 32'hFFFF, {16'h0, `MODE_CLR_ALARM});
        enc_model_i.set_batt('0);
        r = $urandom();
        ret_valid <= 1'b1;
        ret_turns <= r[15:0];
        restart();
        settle();
        cmp("alarm", 32'h0, {31'h0, alarm});
        wr(`OFS_MODE, `MODE_LINEAR);
        rd(`OFS_TURNS, 32'hFFFFFFFF, {{16{r[15]}}, r[15:0]});
        cmp("alarm", 32'h0, {31'h0, alarm});
        ret_valid <= 1'b0;
        b = '0;
        b.battery_dead = 1'b1;
        enc_model_i.set_batt(b);
        settle();
        cmp("alarm", 32'h1, {31'h0, alarm});
        enc_model_i.set_batt('0);
        settle();
        cmp("alarm", 32'h1, {31'h0, alarm});
        wr(`OFS_MODE, `MODE_CLR_TURNS);
        wait_mode(`MODE_LINEAR);
        settle();
        cmp("alarm", 32'h0, {31'h0, alarm});
        $display("test battery done");
        b = '0;
        b.first_use = 1'b1;
        enc_model_i.set_batt(b);
        settle();
        cmp("alarm", 32'h1, {31'h0, alarm});
        cmp("valid", 32'h0, {31'h0, pvalid});
        wr(`OFS_MODE, `MODE_INCR);
        settle();
        cmp("alarm", 32'h0, {31'h0, alarm});
        enc_model_i.set_batt('0);
        $display("test first use done");
        give_verdict();
    end
endmodule // tb
